/* File: src/ftm_defs.svh */
// Constants of the fan tachometer period monitor: offsets, fields,
// reset values and timing counts.
// Assumes a core clock of 250 MHz and an 8-bit register port.
`ifndef FTM_DEFS_SVH
`define FTM_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define FTM_OFS_SLOW_LIMIT 3'h0
`define FTM_OFS_SPEED 3'h1
`define FTM_OFS_CTRL_STATUS 3'h2
`define FTM_OFS_EVENT 3'h3
`define FTM_OFS_EVENT_MASK 3'h4

// ****************************************
// Control/status fields
// ****************************************
`define FTM_CS_READY 0
`define FTM_CS_OVER_LIMIT 1
`define FTM_CS_OVERFLOW 2
`define FTM_CS_IRQ_EN 3
`define FTM_CS_FILT_DIS 4
`define FTM_CS_CLKSEL_LO 5
`define FTM_CS_CLKSEL_HI 6

// ****************************************
// Event status fields
// ****************************************
`define FTM_EV_CAPTURE 0
`define FTM_EV_OVER_LIMIT 1
`define FTM_EV_OVERFLOW 2

// ****************************************
// Reset values
// ****************************************
`define FTM_RST_SLOW_LIMIT 8'hff
`define FTM_RST_SPEED 8'h00
`define FTM_RST_CLKSEL 2'h1
`define FTM_CNT_MAX 8'hff

// ****************************************
// Timing
// ****************************************
`define FTM_CORE_HZ 250000000
`define FTM_CNT_BASE_HZ 16000
`define FTM_FILT_HZ 32000
`define FTM_FILT_MIN_US 750
`define FTM_FILT_SAMPLES ((`FTM_FILT_MIN_US * `FTM_FILT_HZ + 999999) / 1000000)

`endif

/* File: src/ftm_pkg.sv */
// Types shared by the fan tachometer period monitor.
// Assumes ftm_defs.svh supplies all numeric constants.
package ftm_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [2:0] ftm_addr_t;
    typedef logic [7:0] ftm_byte_t;

    typedef enum logic [1:0] {
        FTM_RATE_16K,
        FTM_RATE_8K,
        FTM_RATE_4K,
        FTM_RATE_2K
    } ftm_rate_t;

endpackage : ftm_pkg

/* File: src/ftm_tach_monitor.sv */
// Fan tachometer period monitor: interval counter, capture, limit
// compare, overflow, glitch filter, registers and interrupt.
// Assumes one 250 MHz clock, a synchronous active-low reset and a
// monitor enable driven by logic on the same clock.
//
// Summary of operation
// - Count 8-bit interval at selected rate.
// - Disabled: counter and speed held zero.
// - Later tach edges capture, zero, set ready.
// - Reading speed clears the ready flag.
// - Capture above limit sets over-limit flag.
// - Over-limit freezes speed until clear and read.
// - Counter past FFh: overflow, speed zeroed.
// - Overflow cleared by software, counting resumes.
// - Filter rejects pulses under 750 microseconds.
// - Control bit 4 bypasses the glitch filter.
// - Two-bit field selects counter rate.
// - Encoding 00=16k, 01=8k default, 10=4k, 11=2k.
// - Enable bit gates interrupt on either flag.
// - Writable slow limit, reset value FFh.
// - Writing one clears flag, zero leaves it.
// - Speed register read-only, writes ignored.
`include "ftm_defs.svh"

module ftm_tach_monitor #(
    parameter int unsigned CNT_BASE_DIV = `FTM_CORE_HZ / `FTM_CNT_BASE_HZ,
    parameter int unsigned FILT_DIV = `FTM_CORE_HZ / `FTM_FILT_HZ
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_mon_enable,
    input wire logic i_tach_pulse_input,
    input wire ftm_pkg::ftm_addr_t i_addr,
    input wire ftm_pkg::ftm_byte_t i_wdata,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output ftm_pkg::ftm_byte_t o_rdata,
    output logic o_irq
);
    import ftm_pkg::*;

    localparam logic [4:0] FILT_LAST = 5'(`FTM_FILT_SAMPLES - 1);

    // Rate masks on the base-tick prescaler.
    function automatic logic [2:0] rate_mask(input ftm_rate_t sel);
        logic [2:0] m;
        m = 3'h0;
        case (sel)
            FTM_RATE_16K: m = 3'h0;
            FTM_RATE_8K: m = 3'h1;
            FTM_RATE_4K: m = 3'h3;
            FTM_RATE_2K: m = 3'h7;
            default: m = 3'h0;
        endcase
        return m;
    endfunction : rate_mask

    // ****************************************
    // Declarations
    // ****************************************
    logic tach_meta_reg;
    logic tach_sync_reg;
    logic [13:0] base_div_reg;
    logic base_tick;
    logic [2:0] prescale_reg;
    logic cnt_tick;
    logic [12:0] filt_div_reg;
    logic filt_tick;
    logic [4:0] filt_cnt_reg;
    logic filt_out_reg;
    logic edge_src;
    logic edge_prev_reg;
    logic tach_rise;
    ftm_byte_t slow_limit_reg;
    ftm_byte_t speed_capture_reg;
    ftm_byte_t pulse_interval_count;
    ftm_rate_t clksel_reg;
    logic filt_dis_reg;
    logic irq_en_reg;
    logic overflow_reg;
    logic over_limit_reg;
    logic ready_reg;
    logic armed_reg;
    logic wait_read_reg;
    logic [2:0] event_reg;
    logic [2:0] event_mask_reg;
    logic wr_limit;
    logic wr_cs;
    logic wr_event;
    logic wr_mask;
    logic rd_speed;
    logic frozen;
    logic capture;
    logic count_run;
    logic overflow_set;
    logic over_limit_set;
    ftm_byte_t monitor_ctrl_status_reg;

    assign wr_limit = i_wr_stb && (i_addr == `FTM_OFS_SLOW_LIMIT);
    assign wr_cs = i_wr_stb && (i_addr == `FTM_OFS_CTRL_STATUS);
    assign wr_event = i_wr_stb && (i_addr == `FTM_OFS_EVENT);
    assign wr_mask = i_wr_stb && (i_addr == `FTM_OFS_EVENT_MASK);
    assign rd_speed = i_rd_stb && (i_addr == `FTM_OFS_SPEED);

    // ****************************************
    // Tach synchroniser
    // ****************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            tach_meta_reg <= 1'b0;
            tach_sync_reg <= 1'b0;
        end
        else
        begin
            tach_meta_reg <= i_tach_pulse_input;
            tach_sync_reg <= tach_meta_reg;
        end
    end

    // ****************************************
    // Counter clock generation
    // ****************************************
    assign base_tick = (base_div_reg == 14'(CNT_BASE_DIV - 1));
    assign cnt_tick = base_tick &&
        ((prescale_reg & rate_mask(clksel_reg)) == rate_mask(clksel_reg));

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b || !i_mon_enable)
        begin
            base_div_reg <= 14'h0;
            prescale_reg <= 3'h0;
        end
        else if (base_tick)
        begin
            base_div_reg <= 14'h0;
            prescale_reg <= prescale_reg + 3'h1;
        end
        else
        begin
            base_div_reg <= base_div_reg + 14'h1;
        end
    end

    // ****************************************
    // Glitch filter
    // ****************************************
    // The output follows the input only after it has held a new level
    // for the full run of consecutive filter samples.
    assign filt_tick = (filt_div_reg == 13'(FILT_DIV - 1));

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            filt_div_reg <= 13'h0;
        end
        else if (filt_tick)
        begin
            filt_div_reg <= 13'h0;
        end
        else
        begin
            filt_div_reg <= filt_div_reg + 13'h1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            filt_cnt_reg <= 5'h0;
            filt_out_reg <= 1'b0;
        end
        else if (filt_tick)
        begin
            if (tach_sync_reg == filt_out_reg)
            begin
                filt_cnt_reg <= 5'h0;
            end
            else if (filt_cnt_reg == FILT_LAST)
            begin
                filt_cnt_reg <= 5'h0;
                filt_out_reg <= tach_sync_reg;
            end
            else
            begin
                filt_cnt_reg <= filt_cnt_reg + 5'h1;
            end
        end
    end

    assign edge_src = filt_dis_reg ? tach_sync_reg : filt_out_reg;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            edge_prev_reg <= 1'b0;
        end
        else
        begin
            edge_prev_reg <= edge_src;
        end
    end

    assign tach_rise = edge_src && !edge_prev_reg;

    // ****************************************
    // Interval measurement
    // ****************************************
    assign frozen = over_limit_reg || wait_read_reg;
    assign count_run = i_mon_enable && !overflow_reg;
    assign capture = count_run && tach_rise && armed_reg && !frozen;
    assign overflow_set = count_run && !tach_rise && cnt_tick &&
        (pulse_interval_count == `FTM_CNT_MAX);
    assign over_limit_set = capture &&
        (pulse_interval_count > slow_limit_reg);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b || !i_mon_enable)
        begin
            pulse_interval_count <= 8'h00;
            armed_reg <= 1'b0;
        end
        else if (count_run)
        begin
            if (tach_rise)
            begin
                pulse_interval_count <= 8'h00;
                armed_reg <= 1'b1;
            end
            else if (overflow_set)
            begin
                pulse_interval_count <= 8'h00;
                armed_reg <= 1'b0;
            end
            else if (cnt_tick)
            begin
                pulse_interval_count <= pulse_interval_count + 8'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b || !i_mon_enable)
        begin
            speed_capture_reg <= `FTM_RST_SPEED;
        end
        else if (overflow_set)
        begin
            speed_capture_reg <= `FTM_RST_SPEED;
        end
        else if (capture)
        begin
            speed_capture_reg <= pulse_interval_count;
        end
    end

    // Capture set wins over a same-cycle read clear.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b || !i_mon_enable)
        begin
            ready_reg <= 1'b0;
        end
        else if (capture)
        begin
            ready_reg <= 1'b1;
        end
        else if (overflow_set || rd_speed)
        begin
            ready_reg <= 1'b0;
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            over_limit_reg <= 1'b0;
            overflow_reg <= 1'b0;
        end
        else
        begin
            if (over_limit_set)
            begin
                over_limit_reg <= 1'b1;
            end
            else if (wr_cs && i_wdata[`FTM_CS_OVER_LIMIT])
            begin
                over_limit_reg <= 1'b0;
            end
            if (overflow_set)
            begin
                overflow_reg <= 1'b1;
            end
            else if (wr_cs && i_wdata[`FTM_CS_OVERFLOW])
            begin
                overflow_reg <= 1'b0;
            end
        end
    end

    // After the over-limit flag is cleared, the held reading must still
    // be read once before capturing resumes.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b || !i_mon_enable)
        begin
            wait_read_reg <= 1'b0;
        end
        else if (over_limit_set)
        begin
            wait_read_reg <= 1'b1;
        end
        else if (rd_speed && !over_limit_reg)
        begin
            wait_read_reg <= 1'b0;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            slow_limit_reg <= `FTM_RST_SLOW_LIMIT;
        end
        else if (wr_limit)
        begin
            slow_limit_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            clksel_reg <= ftm_rate_t'(`FTM_RST_CLKSEL);
            filt_dis_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end
        else if (wr_cs)
        begin
            clksel_reg <= ftm_rate_t'(
                i_wdata[`FTM_CS_CLKSEL_HI:`FTM_CS_CLKSEL_LO]);
            filt_dis_reg <= i_wdata[`FTM_CS_FILT_DIS];
            irq_en_reg <= i_wdata[`FTM_CS_IRQ_EN];
        end
    end

    assign monitor_ctrl_status_reg = {1'b0, clksel_reg, filt_dis_reg,
        irq_en_reg, overflow_reg, over_limit_reg, ready_reg};

    // ****************************************
    // Event status and mask
    // ****************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            event_reg <= 3'h0;
            event_mask_reg <= 3'h0;
        end
        else
        begin
            event_reg <= (event_reg & ~(wr_event ? i_wdata[2:0] : 3'h0)) |
                {overflow_set, over_limit_set, capture};
            if (wr_mask)
            begin
                event_mask_reg <= i_wdata[2:0];
            end
        end
    end

    // ****************************************
    // Read port and interrupt
    // ****************************************
    // Speed offset has no write decode, so writes there are dropped.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd_stb)
        begin
            case (i_addr)
                `FTM_OFS_SLOW_LIMIT: o_rdata <= slow_limit_reg;
                `FTM_OFS_SPEED: o_rdata <= speed_capture_reg;
                `FTM_OFS_CTRL_STATUS: o_rdata <= monitor_ctrl_status_reg;
                `FTM_OFS_EVENT: o_rdata <= {5'h00, event_reg};
                `FTM_OFS_EVENT_MASK: o_rdata <= {5'h00, event_mask_reg};
                default: o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= (irq_en_reg && (over_limit_reg || overflow_reg)) ||
                (|(event_reg & event_mask_reg));
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_disabled_zero;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !i_mon_enable |=> (pulse_interval_count == 8'h00) &&
            (speed_capture_reg == 8'h00);
    endproperty
    a_disabled_zero: assert property (p_disabled_zero)
        else $error("Counter or speed not zero while disabled.");

    property p_count_step;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mon_enable && count_run && cnt_tick && !tach_rise &&
            pulse_interval_count != 8'hff) |=>
            pulse_interval_count == $past(pulse_interval_count) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("Interval counter did not advance on a tick.");

    property p_capture;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (capture && i_mon_enable) |=>
            (speed_capture_reg == $past(pulse_interval_count)) &&
            (pulse_interval_count == 8'h00) && ready_reg;
    endproperty
    a_capture: assert property (p_capture)
        else $error("Capture did not load, zero and flag ready.");

    property p_read_clears;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (rd_speed && !capture) |=> !ready_reg;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Speed read left ready set.");

    property p_over_limit;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (capture && pulse_interval_count > slow_limit_reg) |=>
            over_limit_reg ##1 (o_irq || !irq_en_reg);
    endproperty
    a_over_limit: assert property (p_over_limit)
        else $error("Capture above limit missed the flag.");

    property p_freeze;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (frozen && i_mon_enable && !overflow_set) |=>
            $stable(speed_capture_reg) || !i_mon_enable;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Speed changed while frozen.");

    property p_overflow;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        overflow_set |=> overflow_reg && (speed_capture_reg == 8'h00) &&
            !ready_reg;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("Overflow did not flag and clear speed.");

    property p_w1c_hold;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (overflow_reg && !(wr_cs && i_wdata[`FTM_CS_OVERFLOW])) |=>
            overflow_reg;
    endproperty
    a_w1c_hold: assert property (p_w1c_hold)
        else $error("Overflow cleared without a one written.");

    property p_irq;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (irq_en_reg && (over_limit_reg || overflow_reg)) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Enabled flag did not raise the interrupt.");

    property p_bypass;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (filt_dis_reg && tach_sync_reg && !$past(tach_sync_reg)) |->
            tach_rise;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Bypassed filter missed a raw rising edge.");

endmodule : ftm_tach_monitor

/* File: verif/ftm_tach_model.sv */
// Behavioural fan tachometer: a periodic pulse train on one output.
// Assumes the bench supplies period and high time in core clock cycles.
module ftm_tach_model (
    input wire logic i_core_clk,
    input wire logic i_run,
    input wire logic [15:0] i_period,
    input wire logic [15:0] i_high,
    output logic o_tach
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Pulse generator
    // ****************************************
    logic [15:0] phase_reg;

    // A stopped fan rests low, so a restart always gives a fresh rising edge.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_run || (phase_reg + 16'h0001 >= i_period))
            phase_reg <= 16'h0000;
        else
            phase_reg <= phase_reg + 16'h0001;
    end

    assign o_tach = i_run && (phase_reg < i_high);
endmodule : ftm_tach_model

/* File: verif/tb.sv */
// Self-checking bench for the fan tachometer period monitor.
// Assumes the monitor, its package and the fan model are compiled first.
`include "ftm_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ftm_pkg::*;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic mon_en = 1'b0;
    logic tach;
    ftm_addr_t addr = 3'h0;
    ftm_byte_t wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    ftm_byte_t rdata;
    logic irq;
    logic fan_run = 1'b0;
    logic [15:0] fan_period = 16'h0050;
    logic [15:0] fan_high = 16'h0010;
    int error_cnt = 0;
    int n_tests = 0;

    always #2 clk = ~clk;

    ftm_tach_monitor #(.CNT_BASE_DIV(4), .FILT_DIV(2)) dut (
        .i_core_clk(clk),
        .i_rst_b(rst_b),
        .i_mon_enable(mon_en),
        .i_tach_pulse_input(tach),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr_stb(wr_stb),
        .i_rd_stb(rd_stb),
        .o_rdata(rdata),
        .o_irq(irq)
    );

    ftm_tach_model fan (
        .i_core_clk(clk),
        .i_run(fan_run),
        .i_period(fan_period),
        .i_high(fan_high),
        .o_tach(tach)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic test_done;
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input ftm_byte_t e, input ftm_byte_t g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask : chk

    // Interval counts may lose one tick when a tick meets a tach edge.
    task automatic chk_rng(input string nm, input ftm_byte_t lo,
                           input ftm_byte_t g);
        n_tests++;
        if ((^g === 1'bx) || g < lo || g > lo + 8'h01)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h..%h got %h", nm, lo, lo + 8'h01, g);
        end
    endtask : chk_rng

    task automatic wr(input ftm_addr_t a, input ftm_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input ftm_addr_t a, output ftm_byte_t d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic rchk(input string nm, input ftm_addr_t a, input ftm_byte_t e);
        ftm_byte_t v;
        rd(a, v);
        chk(nm, e, v);
    endtask : rchk

    task automatic rrng(input string nm, input ftm_byte_t lo);
        ftm_byte_t v;
        rd(`FTM_OFS_SPEED, v);
        chk_rng(nm, lo, v);
    endtask : rrng

    task automatic irq_chk(input logic e);
        @(posedge clk);
        #1;
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask : irq_chk

    task automatic wait_bit(input int b);
        ftm_byte_t v;
        for (int i = 0; i < 1500; i++)
        begin
            rd(`FTM_OFS_CTRL_STATUS, v);
            if (v[b] === 1'b1)
                return;
        end
        error_cnt++;
        $display("[FAIL] status bit %0d expected 1 got %b", b, v[b]);
        test_done();
    endtask : wait_bit

    // Settings change only while disabled; over-limit and overflow flags are cleared on the way.
    task automatic start(input ftm_byte_t cs, input ftm_byte_t lim,
                         input int per, input int hi);
        @(posedge clk);
        mon_en <= 1'b0;
        fan_run <= 1'b0;
        wr(`FTM_OFS_SLOW_LIMIT, lim);
        wr(`FTM_OFS_CTRL_STATUS, cs | 8'h06);
        rchk("speed off", `FTM_OFS_SPEED, 8'h00);
        @(posedge clk);
        fan_period <= 16'(per);
        fan_high <= 16'(hi);
        mon_en <= 1'b1;
        fan_run <= 1'b1;
    endtask : start

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_reset;
        #1;
        chk("irq rst", 8'h00, {7'h00, irq});
        rchk("limit", `FTM_OFS_SLOW_LIMIT, 8'hff);
        rchk("speed", `FTM_OFS_SPEED, 8'h00);
        rchk("ctrl", `FTM_OFS_CTRL_STATUS, 8'h20);
        rchk("event", `FTM_OFS_EVENT, 8'h00);
        rchk("mask", `FTM_OFS_EVENT_MASK, 8'h00);
        rchk("unmapped", 3'h6, 8'h00);
        wr(`FTM_OFS_SLOW_LIMIT, 8'ha5);
        wr(`FTM_OFS_SPEED, 8'h5a);
        rchk("limit rw", `FTM_OFS_SLOW_LIMIT, 8'ha5);
        rchk("speed ro", `FTM_OFS_SPEED, 8'h00);
    endtask : sc_reset

    task automatic sc_capture;
        ftm_byte_t v;
        start(8'h10, 8'hff, 80, 8);
        wait_bit(`FTM_CS_READY);
        rrng("speed", 8'h13);
        rd(`FTM_OFS_CTRL_STATUS, v);
        chk("ready clr", 8'h00, v & 8'h01);
        wr(`FTM_OFS_SPEED, 8'h00);
        rrng("speed wr", 8'h13);
        wr(`FTM_OFS_EVENT, 8'h07);
        wait_bit(`FTM_CS_READY);
        rchk("event", `FTM_OFS_EVENT, 8'h01);
        wr(`FTM_OFS_EVENT_MASK, 8'h01);
        irq_chk(1'b1);
        wr(`FTM_OFS_EVENT_MASK, 8'h00);
        irq_chk(1'b0);
    endtask : sc_capture

    task automatic sc_clksel;
        for (int s = 0; s < 4; s++)
        begin
            start({1'b0, 2'(s), 5'h10}, 8'hff, (4 << s) * 12, 8);
            wait_bit(`FTM_CS_READY);
            rrng("rate", 8'h0b);
        end
    endtask : sc_clksel

    task automatic sc_limit;
        ftm_byte_t v;
        start(8'h18, 8'h05, 40, 8);
        wait_bit(`FTM_CS_OVER_LIMIT);
        irq_chk(1'b1);
        rd(`FTM_OFS_EVENT, v);
        chk("ovl event", 8'h02, v & 8'h02);
        rrng("over speed", 8'h09);
        fan_period <= 16'h0050;
        repeat (300) @(posedge clk);
        rrng("frozen", 8'h09);
        wr(`FTM_OFS_CTRL_STATUS, 8'h18);
        rd(`FTM_OFS_CTRL_STATUS, v);
        chk("w0 keeps", 8'h02, v & 8'h02);
        wr(`FTM_OFS_CTRL_STATUS, 8'h1a);
        irq_chk(1'b0);
        repeat (200) @(posedge clk);
        rrng("no read yet", 8'h09);
        wait_bit(`FTM_CS_OVER_LIMIT);
        rrng("resumed", 8'h13);
    endtask : sc_limit

    task automatic sc_overflow;
        start(8'h10, 8'hff, 40, 8);
        wait_bit(`FTM_CS_READY);
        fan_run <= 1'b0;
        wr(`FTM_OFS_EVENT, 8'h07);
        wait_bit(`FTM_CS_OVERFLOW);
        rchk("ovf speed", `FTM_OFS_SPEED, 8'h00);
        rchk("ovf event", `FTM_OFS_EVENT, 8'h04);
        rchk("ovf ctrl", `FTM_OFS_CTRL_STATUS, 8'h14);
        chk("irq off", 8'h00, {7'h00, irq});
        wr(`FTM_OFS_CTRL_STATUS, 8'h18);
        irq_chk(1'b1);
        wr(`FTM_OFS_CTRL_STATUS, 8'h1c);
        irq_chk(1'b0);
        fan_run <= 1'b1;
        wait_bit(`FTM_CS_READY);
        rrng("after ovf", 8'h09);
    endtask : sc_overflow

    task automatic sc_filter;
        start(8'h20, 8'hff, 200, 20);
        repeat (800) @(posedge clk);
        rchk("glitch", `FTM_OFS_CTRL_STATUS, 8'h20);
        fan_high <= 16'h0064;
        wait_bit(`FTM_CS_READY);
        rrng("filtered", 8'h18);
    endtask : sc_filter

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        sc_reset();
        sc_capture();
        sc_clksel();
        sc_limit();
        sc_overflow();
        sc_filter();
        // Leave non-default settings and a live interrupt for reset to undo.
        @(posedge clk);
        mon_en <= 1'b0;
        fan_run <= 1'b0;
        wr(`FTM_OFS_SLOW_LIMIT, 8'h3c);
        wr(`FTM_OFS_CTRL_STATUS, 8'h58);
        wr(`FTM_OFS_EVENT_MASK, 8'h07);
        irq_chk(1'b1);
        @(posedge clk);
        rst_b <= 1'b0;
        mon_en <= 1'b0;
        fan_run <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        sc_reset();
        test_done();
    end
endmodule : tb
